// File: verilog/ptd_cfg.svh
// Constants for the task dispatcher: timing counts, field widths and reset values
`ifndef PTD_CFG_SVH
`define PTD_CFG_SVH

// ============================================================
// Timing
`define PTD_CLK_PERIOD_NS 10
`define PTD_POLL_MS 1
`define PTD_TICK_CYCLES ((`PTD_POLL_MS * 1000000) / `PTD_CLK_PERIOD_NS)
`define PTD_CYCLE_RES_MS 10
`define PTD_RES_TICKS (`PTD_CYCLE_RES_MS / `PTD_POLL_MS)

// ============================================================
// Sizes and field positions
`define PTD_TASKS 8
`define PTD_SLOTS 24
`define PTD_TIME_W 32
`define PTD_CLASS_LSB 3

// ============================================================
// Reset values
`define PTD_DIS_RST 1'b0
`define PTD_COLL_RST 8'h00

`endif

// File: verilog/ptd_pkg.sv
// Types shared by the task dispatcher modules
`default_nettype none
package ptd_pkg;

	typedef enum logic [1:0] {
		PTD_CLS_PERIODIC = 2'h0,
		PTD_CLS_EXTERNAL = 2'h1,
		PTD_CLS_INTERNAL = 2'h2
	} ptd_class_t;

	typedef logic [2:0] ptd_level_t;
	typedef logic [4:0] ptd_slot_t;

endpackage
`default_nettype wire

// File: verilog/ptd_rec_mem.sv
// Collision time record store: eight words, per-entry write, clear, registered read
`timescale 1ns/1ps
`default_nettype none
`include "ptd_cfg.svh"

module ptd_rec_mem
	import ptd_pkg::*;
(
	input wire logic clk,                        // core clock
	input wire logic nrst,                       // synchronous reset, active low
	input wire logic clr,                        // wipe every record
	input wire logic [7:0] wr_en,                // one enable per record
	input wire logic [`PTD_TIME_W-1:0] wr_data,  // time written to enabled records
	input wire logic [2:0] rd_idx,               // record to read
	output logic [`PTD_TIME_W-1:0] rd_data       // registered read data
);

	logic [`PTD_TIME_W-1:0] mem_reg [`PTD_TASKS];

	genvar g;
	generate
		for (g = 0; g < `PTD_TASKS; g++) begin : g_rec
			// A new record beats a clear in the same cycle
			always_ff @(posedge clk) begin
				if (!nrst)
					mem_reg[g] <= '0;
				else if (wr_en[g])
					mem_reg[g] <= wr_data;
				else if (clr)
					mem_reg[g] <= '0;
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!nrst)
			rd_data <= '0;
		else
			rd_data <= mem_reg[rd_idx];
	end

endmodule
`default_nettype wire

// File: verilog/ptd_dispatcher.sv
// Priority task dispatcher: periodic, external and internal task requests
// Function
// RULE1: Three task classes, eight tasks each: periodic, external contact, internal variable.
// RULE2: Periodic task requested once per cycle; cycle counted in 10 ms units.
// RULE3: External task requested on rising edge of its input contact.
// RULE4: External contacts sampled every 1 ms; edges raise the bound task.
// RULE5: Internal task requested on variable rising edge or on state.
// RULE6: Internal triggers checked only at scan completion; in-scan pulses are missed.
// RULE7: Levels 0 to 7, level 0 most urgent; most urgent pending runs first.
// RULE8: More urgent request suspends running work, which resumes afterwards.
// RULE9: Scan program ranks lowest and is suspended whenever a task is requested.
// RULE10: No task starts while the initialization program runs.
// RULE11: Disable command blocks task starts; enable command allows them again.
// RULE12: Periodic and external task number equals its level; flags indexed by it.
// RULE13: Periodic request colliding with equal level dropped, flagged, time recorded.
// RULE14: External request on busy contact dropped and flagged in the bitmap.
// RULE15: Periodic time base advances only in RUN; pause time not counted.
// RULE16: External requests accepted only in RUN; pause requests discarded.
// RULE17: Initialization running flag high throughout initialization.
// RULE18: Losing task stays pending and runs before less urgent suspended work.
// RULE19: Collision flag, bitmap and records hold until software clears them.
`timescale 1ns/1ps
`default_nettype none
`include "ptd_cfg.svh"

module ptd_dispatcher
	import ptd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `PTD_TICK_CYCLES
)(
	input wire logic CORE_CLK,                     // core clock, 100 MHz
	input wire logic NRST,                         // synchronous reset, active low
	input wire logic RUN_MODE,                     // 1 RUN, 0 PAUSE
	input wire logic INIT_RUNNING,                 // initialization program executing
	input wire logic TASK_START_DISABLE,           // pulse: block task starts
	input wire logic TASK_START_ENABLE,            // pulse: allow task starts
	input wire logic [7:0] PER_ENABLE,             // periodic task n configured
	input wire logic [255:0] PER_CYCLE,            // cycle of task n, 10 ms units
	input wire logic [7:0] EXT_ENABLE,             // external task n configured
	input wire logic [7:0] EXT_CONTACT,            // contact bound to external task n
	input wire logic [7:0] INT_ENABLE,             // internal task n configured
	input wire logic [7:0] INT_ON_LEVEL,           // 1 on-state trigger, 0 edge
	input wire logic [7:0] INT_VAR,                // Boolean variable of internal task n
	input wire logic [23:0] INT_PRIO,              // level of internal task n
	input wire logic SCAN_DONE,                    // pulse: scan program completed
	input wire logic TASK_DONE,                    // pulse: running task finished
	input wire logic COLL_CLEAR,                   // pulse: clear collision state
	input wire logic [2:0] REC_RD_IDX,             // collision record to read
	output logic RUN_VALID,                        // a task is running
	output logic [1:0] RUN_CLASS,                  // class of running task
	output logic [2:0] RUN_INDEX,                  // number of running task
	output logic [2:0] RUN_LEVEL,                  // level of running task
	output logic TASK_START,                       // pulse: a task was started
	output logic SCAN_SUSPEND,                     // scan program held
	output logic INIT_RUN_FLAG,                    // initialization running
	output logic START_DISABLED,                   // task starts blocked
	output logic COLL_FLAG,                        // collision warning
	output logic [7:0] COLLISION_BITMAP,           // collision per task number
	output logic [`PTD_TIME_W-1:0] REC_RD_DATA     // collision time record
);

	// ============================================================
	// Time base
	logic [31:0] tick_cnt_reg;
	logic ms_tick_reg;
	logic [3:0] res_cnt_reg;
	logic [`PTD_TIME_W-1:0] run_time_reg;
	wire res_tick = ms_tick_reg && RUN_MODE && (res_cnt_reg == 4'(`PTD_RES_TICKS - 1));

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			tick_cnt_reg <= '0;
			ms_tick_reg <= 1'b0;
		end else begin
			ms_tick_reg <= (tick_cnt_reg == TICK_CYCLES - 1); // RULE4
			tick_cnt_reg <= (tick_cnt_reg == TICK_CYCLES - 1) ? '0 : tick_cnt_reg + 32'h1;
		end
	end

	// Only RUN ticks advance the resolution counter and the run clock
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			res_cnt_reg <= '0;
			run_time_reg <= '0;
		end else if (ms_tick_reg && RUN_MODE) begin // RULE15
			res_cnt_reg <= res_tick ? 4'h0 : res_cnt_reg + 4'h1;
			if (res_tick)
				run_time_reg <= run_time_reg + 32'h1;
		end
	end

	// ============================================================
	// Running stack: one entry per level
	logic [7:0] active_reg;
	ptd_slot_t slot_reg [`PTD_TASKS];
	logic [7:0] pend_per_reg, pend_ext_reg, pend_int_reg;
	logic dis_reg;

	// ============================================================
	// Periodic requests
	logic [7:0] per_req, per_busy, lvl_int_pend;
	logic [31:0] per_cnt_reg [`PTD_TASKS];

	genvar g;
	generate
		for (g = 0; g < `PTD_TASKS; g++) begin : g_per
			wire [31:0] cyc = PER_CYCLE[g*32 +: 32];
			assign per_req[g] = res_tick && PER_ENABLE[g] && (cyc != 32'h0) &&
				(per_cnt_reg[g] >= cyc - 32'h1); // RULE2
			always_ff @(posedge CORE_CLK) begin
				if (!NRST || !PER_ENABLE[g])
					per_cnt_reg[g] <= '0;
				else if (res_tick)
					per_cnt_reg[g] <= per_req[g] ? 32'h0 : per_cnt_reg[g] + 32'h1;
			end
			// Equal level busy: running or pending in any class
			assign per_busy[g] = active_reg[g] || pend_per_reg[g] || pend_ext_reg[g] ||
				lvl_int_pend[g]; // RULE13
		end
	endgenerate

	always_comb begin
		lvl_int_pend = 8'h00;
		for (int k = 0; k < `PTD_TASKS; k++)
			if (pend_int_reg[k])
				lvl_int_pend[INT_PRIO[k*3 +: 3]] = 1'b1;
	end

	// ============================================================
	// External and internal requests
	logic [7:0] ext_prev_reg, int_prev_reg;
	wire [7:0] ext_edge = EXT_CONTACT & ~ext_prev_reg & EXT_ENABLE & {8{ms_tick_reg}}; // RULE3
	wire [7:0] ext_acc = ext_edge & {8{RUN_MODE}}; // RULE16
	logic [7:0] ext_busy;
	wire [7:0] int_trig = INT_ENABLE & (INT_VAR & (INT_ON_LEVEL | ~int_prev_reg)); // RULE5
	wire [7:0] int_set = int_trig & {8{SCAN_DONE}}; // RULE6

	generate
		for (g = 0; g < `PTD_TASKS; g++) begin : g_ext
			assign ext_busy[g] = pend_ext_reg[g] || (active_reg[g] &&
				slot_reg[g] == {PTD_CLS_EXTERNAL, 3'(g)}); // RULE14
		end
	endgenerate

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ext_prev_reg <= '0;
			int_prev_reg <= '0;
		end else begin
			if (ms_tick_reg)
				ext_prev_reg <= EXT_CONTACT; // RULE4
			if (SCAN_DONE)
				int_prev_reg <= INT_VAR; // RULE6
		end
	end

	wire [7:0] per_set = per_req & ~per_busy;
	wire [7:0] ext_set = ext_acc & ~ext_busy;
	wire [7:0] per_coll = per_req & per_busy; // RULE13
	wire [7:0] coll_set = per_coll | (ext_acc & ext_busy); // RULE14

	// ============================================================
	// Arbitration
	wire [23:0] pend_all = {pend_int_reg, pend_ext_reg, pend_per_reg}; // RULE1
	ptd_level_t cand_lvl [`PTD_SLOTS];
	logic best_hit;
	ptd_level_t best_lvl;
	ptd_slot_t best_id;

	generate
		for (g = 0; g < `PTD_TASKS; g++) begin : g_lvl
			assign cand_lvl[g] = 3'(g); // RULE12
			assign cand_lvl[g + 8] = 3'(g); // RULE12
			assign cand_lvl[g + 16] = INT_PRIO[g*3 +: 3];
		end
	endgenerate

	// Lowest level wins; ties go to the lower slot number
	always_comb begin
		best_hit = 1'b0;
		best_lvl = 3'h7;
		best_id = 5'h00;
		for (int i = 0; i < `PTD_SLOTS; i++) begin
			if (pend_all[i] && (!best_hit || cand_lvl[i] < best_lvl)) begin // RULE7
				best_hit = 1'b1;
				best_lvl = cand_lvl[i];
				best_id = 5'(i);
			end
		end
	end

	wire [7:0] done_bit = TASK_DONE ? (active_reg & (~active_reg + 8'h01)) : 8'h00;
	wire [7:0] active_after = active_reg & ~done_bit;
	logic cur_hit;
	ptd_level_t cur_lvl;

	always_comb begin
		cur_hit = 1'b0;
		cur_lvl = 3'h7;
		for (int i = `PTD_TASKS - 1; i >= 0; i--) begin
			if (active_after[i]) begin
				cur_hit = 1'b1;
				cur_lvl = 3'(i);
			end
		end
	end

	wire start_ok = RUN_MODE && !INIT_RUNNING && !dis_reg; // RULE10 RULE11
	// A pending task beats suspended work of a lower urgency
	wire start_now = start_ok && best_hit && (!cur_hit || best_lvl < cur_lvl); // RULE8 RULE18
	wire [7:0] start_bit = start_now ? (8'h01 << best_lvl) : 8'h00;
	wire [7:0] active_next = active_after | start_bit;
	wire [23:0] pend_clr = start_now ? (24'h000001 << best_id) : 24'h000000;
	wire [23:0] pend_next = (pend_all & ~pend_clr) | {int_set, ext_set, per_set}; // RULE18
	// Idle shows zeros: with no level active, 5'h00 is selected instead of slot_reg
	wire ptd_slot_t run_id_next = start_now ? best_id : (cur_hit ? slot_reg[cur_lvl] : 5'h00);
	wire ptd_level_t run_lvl_next = start_now ? best_lvl : (cur_hit ? cur_lvl : 3'h0);

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			active_reg <= '0;
			{pend_int_reg, pend_ext_reg, pend_per_reg} <= '0;
		end else begin
			active_reg <= active_next; // RULE8
			{pend_int_reg, pend_ext_reg, pend_per_reg} <= pend_next;
			if (start_now)
				slot_reg[best_lvl] <= best_id;
		end
	end

	// ============================================================
	// Commands, status and collision state
	always_ff @(posedge CORE_CLK) begin
		if (!NRST)
			dis_reg <= `PTD_DIS_RST;
		else if (TASK_START_DISABLE)
			dis_reg <= 1'b1; // RULE11
		else if (TASK_START_ENABLE)
			dis_reg <= 1'b0; // RULE11
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			RUN_VALID <= 1'b0;
			RUN_CLASS <= '0;
			RUN_INDEX <= '0;
			RUN_LEVEL <= '0;
			TASK_START <= 1'b0;
			SCAN_SUSPEND <= 1'b0;
			INIT_RUN_FLAG <= 1'b0;
			START_DISABLED <= 1'b0;
			COLL_FLAG <= 1'b0;
			COLLISION_BITMAP <= `PTD_COLL_RST;
		end else begin
			RUN_VALID <= |active_next;
			RUN_CLASS <= run_id_next[4:`PTD_CLASS_LSB];
			RUN_INDEX <= run_id_next[2:0];
			RUN_LEVEL <= run_lvl_next;
			TASK_START <= start_now;
			SCAN_SUSPEND <= (|active_next) || (|pend_next); // RULE9
			INIT_RUN_FLAG <= INIT_RUNNING; // RULE17
			START_DISABLED <= dis_reg;
			// New collisions win over a clear in the same cycle
			COLL_FLAG <= (COLL_FLAG && !COLL_CLEAR) || (|coll_set); // RULE19
			COLLISION_BITMAP <= (COLLISION_BITMAP & ~{8{COLL_CLEAR}}) | coll_set; // RULE19
		end
	end

	ptd_rec_mem u_rec (
		.clk(CORE_CLK),
		.nrst(NRST),
		.clr(COLL_CLEAR),
		.wr_en(per_coll), // RULE13
		.wr_data(run_time_reg),
		.rd_idx(REC_RD_IDX),
		.rd_data(REC_RD_DATA)
	);

	// ============================================================
	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	sequence s_disable_cmd;
		TASK_START_DISABLE ##1 1'b1;
	endsequence
	sequence s_coll_held;
		COLL_FLAG && !COLL_CLEAR;
	endsequence

	chk_init_block: assert property (INIT_RUNNING |=> !TASK_START) // RULE10
		else $error("task started during initialization");
	chk_disable_cmd: assert property (s_disable_cmd |-> !start_now) // RULE11
		else $error("task started after disable command");
	chk_preempt_level: assert property (start_now && cur_hit |=> // RULE8
		TASK_START && RUN_LEVEL < $past(cur_lvl) && active_reg[$past(cur_lvl)])
		else $error("start without outranking or keeping suspended work");
	chk_coll_sticky: assert property (s_coll_held |=> COLL_FLAG [*1]) // RULE19
		else $error("collision flag lost without clear");
	chk_per_drop: assert property ((per_coll != 8'h00) |=> COLL_FLAG && // RULE13
		((COLLISION_BITMAP & $past(per_coll)) == $past(per_coll)))
		else $error("periodic collision not flagged");
	chk_time_freeze: assert property (!RUN_MODE |=> $stable(run_time_reg)) // RULE15
		else $error("time base moved in pause");
	chk_ext_pause: assert property (!RUN_MODE |=> // RULE16
		(pend_ext_reg & ~$past(pend_ext_reg)) == 8'h00)
		else $error("external request accepted in pause");
	chk_int_scan: assert property (((pend_int_reg & ~$past(pend_int_reg)) != 8'h00) |-> // RULE6
		$past(SCAN_DONE))
		else $error("internal request outside scan completion");
	chk_scan_hold: assert property ((active_reg != 8'h00) |-> SCAN_SUSPEND) // RULE9
		else $error("scan not suspended while a task runs");
	chk_init_flag: assert property (INIT_RUNNING ##1 INIT_RUNNING |-> INIT_RUN_FLAG) // RULE17
		else $error("init flag low during initialization");

endmodule
`default_nettype wire

// File: sim/ptd_exec_model.sv
// Execution engine model: ends tasks and scans
`timescale 1ns/1ps
`default_nettype none
module ptd_exec_model (
	input wire logic clk,           // core clock
	input wire logic nrst,          // reset, active low
	input wire logic hold,          // keep running task busy
	input wire logic [7:0] run_len, // task length in cycles
	input wire logic run_valid,     // a task runs
	input wire logic task_start,    // a task started
	input wire logic scan_hold,     // scan program held
	output logic task_done,         // task finished
	output logic scan_done          // scan finished
);
	logic [7:0] cnt_reg;
	logic [5:0] scan_reg;
	// Resumed work restarts its length count
	always_ff @(posedge clk) begin
		if (!nrst || task_start || task_done) begin
			cnt_reg <= 8'h00;
		end else if (run_valid && !hold) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
		task_done <= nrst && run_valid && !hold && !task_done && cnt_reg == run_len;
	end
	// Scan only advances while no task is active
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scan_reg <= 6'h00;
			scan_done <= 1'b0;
		end else begin
			scan_done <= !scan_hold && scan_reg == 6'h27;
			if (!scan_hold) begin
				scan_reg <= (scan_reg == 6'h27) ? 6'h00 : scan_reg + 6'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the task dispatcher
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, nrst = 1'b0, run_mode = 1'b0, init_run = 1'b0;
	logic dis = 1'b0, ena = 1'b0, coll_clr = 1'b0, hold = 1'b1;
	logic scan_done, task_done, rv, ts, ss, irf, sd, cf, hit;
	logic [7:0] per_en = 8'h00, ext_en = 8'h00, ext_c = 8'h00, int_en = 8'h00;
	logic [7:0] int_lvl = 8'h00, int_var = 8'h00, run_len = 8'h14, cb;
	logic [255:0] per_cyc = '0;
	logic [23:0] int_prio = 24'h000000;
	logic [2:0] rd_idx = 3'h0, ri, rl, n, m, p;
	logic [1:0] rc;
	logic [31:0] rd;
	int n_errors = 0, total_checks = 0, cycles = 0;

	ptd_dispatcher #(.TICK_CYCLES(10)) i_ptd_dispatcher (.CORE_CLK(clk), .NRST(nrst),
		.RUN_MODE(run_mode), .INIT_RUNNING(init_run), .TASK_START_DISABLE(dis),
		.TASK_START_ENABLE(ena), .PER_ENABLE(per_en), .PER_CYCLE(per_cyc),
		.EXT_ENABLE(ext_en), .EXT_CONTACT(ext_c), .INT_ENABLE(int_en),
		.INT_ON_LEVEL(int_lvl), .INT_VAR(int_var), .INT_PRIO(int_prio),
		.SCAN_DONE(scan_done), .TASK_DONE(task_done), .COLL_CLEAR(coll_clr),
		.REC_RD_IDX(rd_idx), .RUN_VALID(rv), .RUN_CLASS(rc), .RUN_INDEX(ri),
		.RUN_LEVEL(rl), .TASK_START(ts), .SCAN_SUSPEND(ss), .INIT_RUN_FLAG(irf),
		.START_DISABLED(sd), .COLL_FLAG(cf), .COLLISION_BITMAP(cb), .REC_RD_DATA(rd));
	ptd_exec_model i_ptd_exec_model (.clk(clk), .nrst(nrst), .hold(hold),
		.run_len(run_len), .run_valid(rv), .task_start(ts), .scan_hold(ss),
		.task_done(task_done), .scan_done(scan_done));

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	// ====================
	// Helpers
	function automatic logic [7:0] bitn(input logic [2:0] k);
		return 8'h01 << k;
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wstart(input int lim, output logic h);
		h = 1'b0;
		for (int i = 0; i < lim && !h; i++) begin
			@(posedge clk);
			#1;
			h = (ts === 1'b1);
		end
	endtask
	task automatic wev(input logic scan);
		int i;
		i = 0;
		while ((scan ? scan_done : task_done) !== 1'b1 && i < 300) begin
			@(posedge clk);
			#1;
			i++;
		end
		cmp("event", 1, i < 300);
		cyc(2);
	endtask
	task automatic ext_hit(input logic [2:0] k, input logic e);
		logic h;
		@(posedge clk);
		ext_c[k] <= 1'b1;
		wstart(30, h);
		cmp("ext start", e, h);
		if (h) cmp("ext task", {2'h1, k, k}, {rc, ri, rl});
		@(posedge clk);
		ext_c[k] <= 1'b0;
		cyc(25);
	endtask
	task automatic clear;
		@(posedge clk);
		coll_clr <= 1'b1;
		@(posedge clk);
		coll_clr <= 1'b0;
		cyc(2);
		cmp("cleared", 0, {cf, cb, rd});
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ====================
	// Tests
	initial begin
		void'($urandom(32'h63a8c69e));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		cyc(2);
		cmp("reset", 0, {rv, rc, ri, rl, ts, ss, irf, sd, cf, cb});
		tend("reset");
		n = 3'($urandom_range(7, 4));
		m = n - 3'h3;
		@(posedge clk);
		run_len <= 8'($urandom_range(60, 20));
		run_mode <= 1'b1;
		ext_en <= 8'hff;
		ext_hit(n, 1'b1);
		cmp("scan hold", 1, ss);
		ext_hit(m, 1'b1);
		ext_hit(m, 1'b0);
		cmp("coll", {1'b1, bitn(m)}, {cf, cb});
		@(posedge clk);
		hold <= 1'b0;
		wev(1'b0);
		cmp("resume", {1'b1, n}, {rv, ri});
		wev(1'b0);
		cmp("idle", 0, {rv, ss});
		cmp("coll kept", 1, cf);
		clear();
		tend("external");
		p = 3'($urandom_range(7, 0));
		@(posedge clk);
		init_run <= 1'b1;
		ext_hit(p, 1'b0);
		cmp("init flag", 1, irf);
		@(posedge clk);
		init_run <= 1'b0;
		wstart(10, hit);
		cmp("after init", {1'b1, p}, {hit, ri});
		wev(1'b0);
		tend("init");
		@(posedge clk);
		dis <= 1'b1;
		@(posedge clk);
		dis <= 1'b0;
		cyc(1);
		cmp("disabled", 1, sd);
		ext_hit(m, 1'b0);
		@(posedge clk);
		ena <= 1'b1;
		@(posedge clk);
		ena <= 1'b0;
		wstart(10, hit);
		cmp("enabled", {1'b1, m}, {hit, ri});
		wev(1'b0);
		tend("disable");
		@(posedge clk);
		run_mode <= 1'b0;
		ext_hit(n, 1'b0);
		@(posedge clk);
		run_mode <= 1'b1;
		wstart(40, hit);
		cmp("pause drop", 0, hit);
		tend("pause");
		p = 3'($urandom_range(7, 0));
		@(posedge clk);
		int_prio <= {8{3'h5}};
		int_en <= bitn(p);
		wev(1'b1);
		@(posedge clk);
		int_var[p] <= 1'b1;
		cyc(5);
		@(posedge clk);
		int_var[p] <= 1'b0;
		wstart(90, hit);
		cmp("short pulse", 0, hit);
		@(posedge clk);
		int_var[p] <= 1'b1;
		wstart(90, hit);
		cmp("int edge", {1'b1, 2'h2, p, 3'h5}, {hit, rc, ri, rl});
		@(posedge clk);
		int_lvl <= bitn(p);
		wev(1'b0);
		wstart(120, hit);
		cmp("int level", 1, hit);
		@(posedge clk);
		int_en <= 8'h00;
		int_var <= 8'h00;
		cyc(150);
		tend("internal");
		@(posedge clk);
		hold <= 1'b1;
		per_cyc[32 * p +: 32] <= 32'h1;
		per_en <= bitn(p);
		wstart(130, hit);
		cmp("periodic", {1'b1, 2'h0, p, p}, {hit, rc, ri, rl});
		cyc(110);
		@(posedge clk);
		rd_idx <= p;
		cyc(2);
		cmp("per coll", {1'b1, bitn(p), 1'b1}, {cf, cb, rd !== 32'h0});
		@(posedge clk);
		hold <= 1'b0;
		per_en <= 8'h00;
		clear();
		@(posedge clk);
		per_cyc[32 * p +: 32] <= 32'h2;
		per_en <= bitn(p);
		wstart(250, hit);
		cmp("cycle two", 1, hit);
		@(posedge clk);
		run_mode <= 1'b0;
		cyc(500);
		@(posedge clk);
		run_mode <= 1'b1;
		wstart(150, hit);
		cmp("paused time", 0, hit);
		wstart(80, hit);
		cmp("cycle resumed", 1, hit);
		tend("periodic");
		end_sim();
	end
endmodule
`default_nettype wire
